/* pkg/gpio_ports_map.svh */
// Purpose: Offsets, field masks and reset values of the port G/H/J register block.
// Assumes: Byte-wide registers at the printed offsets.
// Notes: Reserved bits read as zero through the implemented-bit masks.
`ifndef GPIO_PORTS_MAP_SVH
`define GPIO_PORTS_MAP_SVH

`define G_PULL_ENABLE_OFS 8'h14
`define G_POLARITY_SELECT_OFS 8'h15
`define G_IRQ_ENABLE_OFS 8'h16
`define G_EDGE_FLAGS_OFS 8'h17
`define H_DATA_OFS 8'h18
`define H_PIN_INPUT_OFS 8'h19
`define H_DIRECTION_OFS 8'h1a
`define H_REDUCED_DRIVE_OFS 8'h1b
`define H_PULL_ENABLE_OFS 8'h1c
`define H_POLARITY_SELECT_OFS 8'h1d
`define H_IRQ_ENABLE_OFS 8'h1e
`define H_EDGE_FLAGS_OFS 8'h1f
`define J_DATA_OFS 8'h20
`define J_PIN_INPUT_OFS 8'h21
`define J_DIRECTION_OFS 8'h22

`define H_IMPL_MASK 8'h7f
`define J_IMPL_MASK 8'hcf
`define G_MII_MASK 8'h7f
`define H_MII_MASK 8'h7f
`define J_MII_MASK 8'h0f
`define J_TWI_MASK 8'hc0
`define J_TWI_LSB 6

`define REG_RESET 8'h00

`endif

/* pkg/gpio_ports_pkg.sv */
// Purpose: Shared types of the port G/H/J block.
// Assumes: Eight pin positions per port.
// Notes: Constants live in gpio_ports_map.svh.
package gpio_ports_pkg;
	typedef logic [7:0] pin_vec_t;
	typedef logic [7:0] reg_addr_t;
endpackage : gpio_ports_pkg

/* hdl/gpio_ports_g_h_j.sv */
// Purpose: General-purpose I/O logic for ports G, H and J with edge interrupts.
// Assumes: Single core clock; pins and peripheral override enables arrive as noted per port.
// Notes: Every top-level output is registered, so pin control follows a register write
// Notes: by one clock edge.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "gpio_ports_map.svh"

module gpio_ports_g_h_j
	import gpio_ports_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port.
	input wire reg_addr_t reg_addr,
	input wire pin_vec_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output pin_vec_t reg_rdata,
	// Peripheral takeover enables and peripheral-side signals.
	input wire logic ext_mii_en,
	input wire logic two_wire_en,
	input wire pin_vec_t g_direction,
	input wire pin_vec_t mii_h_out,
	input wire pin_vec_t mii_j_out,
	input wire pin_vec_t mii_j_oe,
	input wire pin_vec_t twi_j_out,
	input wire pin_vec_t twi_j_oe,
	// Port G pins.
	input wire pin_vec_t g_pin_in,
	output pin_vec_t g_pull_on,
	output pin_vec_t g_pull_down,
	output pin_vec_t g_pin_sync,
	// Port H pins.
	input wire pin_vec_t h_pin_in,
	output pin_vec_t h_pin_out,
	output pin_vec_t h_pin_oe,
	output pin_vec_t h_pin_weak,
	output pin_vec_t h_pull_on,
	output pin_vec_t h_pull_down,
	// Port J pins.
	input wire pin_vec_t j_pin_in,
	output pin_vec_t j_pin_out,
	output pin_vec_t j_pin_oe,
	output pin_vec_t j_pin_sync,
	// Interrupt requests.
	output logic g_irq,
	output logic h_irq,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// Software-visible registers.
	pin_vec_t g_pull_enable_reg; // Port G pull enables.
	pin_vec_t g_polarity_select_reg; // Port G edge and pull polarity.
	pin_vec_t g_irq_enable_reg; // Port G interrupt enables.
	pin_vec_t g_edge_flags_reg; // Port G sticky edge flags.
	pin_vec_t h_data_reg; // Port H output latch.
	pin_vec_t h_direction_reg; // Port H direction.
	pin_vec_t h_reduced_drive_reg; // Port H drive strength.
	pin_vec_t h_pull_enable_reg; // Port H pull enables.
	pin_vec_t h_polarity_select_reg; // Port H edge and pull polarity.
	pin_vec_t h_irq_enable_reg; // Port H interrupt enables.
	pin_vec_t h_edge_flags_reg; // Port H sticky edge flags.
	pin_vec_t j_data_reg; // Port J output latch.
	pin_vec_t j_direction_reg; // Port J direction.

	// Synchroniser stages; the meta stages feed only the sync stages.
	pin_vec_t g_meta_reg;
	pin_vec_t g_sync_reg;
	pin_vec_t g_prev_reg;
	pin_vec_t h_meta_reg;
	pin_vec_t h_sync_reg;
	pin_vec_t h_prev_reg;
	pin_vec_t j_meta_reg;
	pin_vec_t j_sync_reg;
	// Settling marks, one per stage: a set bit means that stage now holds a real
	// pin sample rather than its reset zero. Edges are ignored until the prev
	// stage is real, so a pin that already sits high at reset gives no false edge.
	logic [2:0] settle_reg;

	// Decoded write strobes and edge events.
	logic wr_g_flags;
	logic wr_h_flags;
	pin_vec_t g_edge;
	pin_vec_t h_edge;
	pin_vec_t g_dir_eff;
	pin_vec_t h_dir_eff;
	pin_vec_t j_dir_eff;
	pin_vec_t h_out_next;
	pin_vec_t j_out_next;
	pin_vec_t rdata_next;

	assign wr_g_flags = reg_wr && (reg_addr == `G_EDGE_FLAGS_OFS);
	assign wr_h_flags = reg_wr && (reg_addr == `H_EDGE_FLAGS_OFS);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers. Two stages before any logic; a third stage keeps the
	// previous settled level for edge detection.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			g_meta_reg <= `REG_RESET;
			g_sync_reg <= `REG_RESET;
			g_prev_reg <= `REG_RESET;
			h_meta_reg <= `REG_RESET;
			h_sync_reg <= `REG_RESET;
			h_prev_reg <= `REG_RESET;
			j_meta_reg <= `REG_RESET;
			j_sync_reg <= `REG_RESET;
			settle_reg <= 3'h0;
		end else begin
			g_meta_reg <= g_pin_in;
			g_sync_reg <= g_meta_reg;
			g_prev_reg <= g_sync_reg;
			h_meta_reg <= h_pin_in & `H_IMPL_MASK;
			h_sync_reg <= h_meta_reg;
			h_prev_reg <= h_sync_reg;
			j_meta_reg <= j_pin_in & `J_IMPL_MASK;
			j_sync_reg <= j_meta_reg;
			// One mark per edge after release; the third one arms edge detection.
			settle_reg <= {settle_reg[1:0], 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge detection. The polarity bit picks rising or falling per pin. Edges
	// wait for the third settling mark, so the reset zeros of the sync and prev
	// stages are never compared against a live pin level; the price is that a
	// pin moving before the first edge after reset release raises no flag.
	always_comb begin
		g_edge = ((g_polarity_select_reg & g_sync_reg & ~g_prev_reg)
			| (~g_polarity_select_reg & ~g_sync_reg & g_prev_reg))
			& {8{settle_reg[2]}};
		h_edge = ((h_polarity_select_reg & h_sync_reg & ~h_prev_reg)
			| (~h_polarity_select_reg & ~h_sync_reg & h_prev_reg)) & `H_IMPL_MASK
			& {8{settle_reg[2]}};
	end

	////////////////////////////////////////////////////////////////////////////
	// Port G configuration registers.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			g_pull_enable_reg <= `REG_RESET;
			g_polarity_select_reg <= `REG_RESET;
			g_irq_enable_reg <= `REG_RESET;
		end else if (reg_wr) begin
			// Each register accepts a write at any time.
			if (reg_addr == `G_PULL_ENABLE_OFS) begin
				g_pull_enable_reg <= reg_wdata;
			end
			if (reg_addr == `G_POLARITY_SELECT_OFS) begin
				g_polarity_select_reg <= reg_wdata;
			end
			if (reg_addr == `G_IRQ_ENABLE_OFS) begin
				g_irq_enable_reg <= reg_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky edge flags. A new edge in the cycle of a clearing write wins, so
	// no event is lost between the read and the acknowledge.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			g_edge_flags_reg <= `REG_RESET;
			h_edge_flags_reg <= `REG_RESET;
		end else begin
			g_edge_flags_reg <= (g_edge_flags_reg
				& ~(wr_g_flags ? reg_wdata : `REG_RESET)) | g_edge;
			h_edge_flags_reg <= ((h_edge_flags_reg
				& ~(wr_h_flags ? reg_wdata : `REG_RESET)) | h_edge) & `H_IMPL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Port H configuration registers; unimplemented bits never store.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			h_data_reg <= `REG_RESET;
			h_direction_reg <= `REG_RESET;
			h_reduced_drive_reg <= `REG_RESET;
			h_pull_enable_reg <= `REG_RESET;
			h_polarity_select_reg <= `REG_RESET;
			h_irq_enable_reg <= `REG_RESET;
		end else if (reg_wr) begin
			if (reg_addr == `H_DATA_OFS) begin
				h_data_reg <= reg_wdata & `H_IMPL_MASK;
			end
			if (reg_addr == `H_DIRECTION_OFS) begin
				h_direction_reg <= reg_wdata & `H_IMPL_MASK;
			end
			if (reg_addr == `H_REDUCED_DRIVE_OFS) begin
				h_reduced_drive_reg <= reg_wdata & `H_IMPL_MASK;
			end
			if (reg_addr == `H_PULL_ENABLE_OFS) begin
				h_pull_enable_reg <= reg_wdata & `H_IMPL_MASK;
			end
			if (reg_addr == `H_POLARITY_SELECT_OFS) begin
				h_polarity_select_reg <= reg_wdata & `H_IMPL_MASK;
			end
			if (reg_addr == `H_IRQ_ENABLE_OFS) begin
				h_irq_enable_reg <= reg_wdata & `H_IMPL_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Port J configuration registers.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			j_data_reg <= `REG_RESET;
			j_direction_reg <= `REG_RESET;
		end else if (reg_wr) begin
			if (reg_addr == `J_DATA_OFS) begin
				j_data_reg <= reg_wdata & `J_IMPL_MASK;
			end
			if (reg_addr == `J_DIRECTION_OFS) begin
				j_direction_reg <= reg_wdata & `J_IMPL_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Effective direction and output value after peripheral takeover. The MII
	// receive pins of port G become inputs, its transmit pins on port H become
	// outputs, and on port J the owning controller supplies value and enable.
	always_comb begin
		g_dir_eff = ext_mii_en ? (g_direction & ~`G_MII_MASK) : g_direction;
		h_dir_eff = ext_mii_en ? (h_direction_reg | `H_MII_MASK) : h_direction_reg;
		h_out_next = ext_mii_en ? ((mii_h_out & `H_MII_MASK) | (h_data_reg & ~`H_MII_MASK))
			: h_data_reg;
		j_dir_eff = j_direction_reg;
		j_out_next = j_data_reg;
		if (ext_mii_en) begin
			j_dir_eff = (j_dir_eff & ~`J_MII_MASK) | (mii_j_oe & `J_MII_MASK);
			j_out_next = (j_out_next & ~`J_MII_MASK) | (mii_j_out & `J_MII_MASK);
		end
		if (two_wire_en) begin
			j_dir_eff = (j_dir_eff & ~`J_TWI_MASK) | (twi_j_oe & `J_TWI_MASK);
			j_out_next = (j_out_next & ~`J_TWI_MASK) | (twi_j_out & `J_TWI_MASK);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pad controls. Pulls follow the effective direction: a driven pin never
	// carries a pull, and reduced drive means nothing on an input.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			g_pull_on <= `REG_RESET;
			g_pull_down <= `REG_RESET;
			h_pin_out <= `REG_RESET;
			h_pin_oe <= `REG_RESET;
			h_pin_weak <= `REG_RESET;
			h_pull_on <= `REG_RESET;
			h_pull_down <= `REG_RESET;
			j_pin_out <= `REG_RESET;
			j_pin_oe <= `REG_RESET;
		end else begin
			g_pull_on <= g_pull_enable_reg & ~g_dir_eff;
			g_pull_down <= g_pull_enable_reg & ~g_dir_eff & g_polarity_select_reg;
			h_pin_out <= h_out_next & `H_IMPL_MASK;
			h_pin_oe <= h_dir_eff & `H_IMPL_MASK;
			h_pin_weak <= h_reduced_drive_reg & h_dir_eff & `H_IMPL_MASK;
			h_pull_on <= h_pull_enable_reg & ~h_dir_eff & `H_IMPL_MASK;
			h_pull_down <= h_pull_enable_reg & ~h_dir_eff & h_polarity_select_reg
				& `H_IMPL_MASK;
			j_pin_out <= j_out_next & `J_IMPL_MASK;
			j_pin_oe <= j_dir_eff & `J_IMPL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Settled pin levels handed to the MAC and the two-wire controller.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			g_pin_sync <= `REG_RESET;
			j_pin_sync <= `REG_RESET;
		end else begin
			g_pin_sync <= g_sync_reg;
			j_pin_sync <= j_sync_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt requests: one each for ports G and H plus their union. Registered, so the
	// request trails the flag by one edge.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			g_irq <= 1'b0;
			h_irq <= 1'b0;
			irq <= 1'b0;
		end else begin
			g_irq <= |(g_edge_flags_reg & g_irq_enable_reg);
			h_irq <= |(h_edge_flags_reg & h_irq_enable_reg);
			irq <= |(g_edge_flags_reg & g_irq_enable_reg)
				| |(h_edge_flags_reg & h_irq_enable_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read multiplexer. Data reads mix the latch and the settled pin by the
	// direction bit; since pins pass two stages, a direction change shows on
	// the pin half only after the synchroniser has refilled.
	always_comb begin
		rdata_next = `REG_RESET;
		unique case (reg_addr)
			`G_PULL_ENABLE_OFS: rdata_next = g_pull_enable_reg;
			`G_POLARITY_SELECT_OFS: rdata_next = g_polarity_select_reg;
			`G_IRQ_ENABLE_OFS: rdata_next = g_irq_enable_reg;
			`G_EDGE_FLAGS_OFS: rdata_next = g_edge_flags_reg;
			`H_DATA_OFS: rdata_next = (h_data_reg & h_direction_reg)
				| (h_sync_reg & ~h_direction_reg);
			`H_PIN_INPUT_OFS: rdata_next = h_sync_reg;
			`H_DIRECTION_OFS: rdata_next = h_direction_reg;
			`H_REDUCED_DRIVE_OFS: rdata_next = h_reduced_drive_reg;
			`H_PULL_ENABLE_OFS: rdata_next = h_pull_enable_reg;
			`H_POLARITY_SELECT_OFS: rdata_next = h_polarity_select_reg;
			`H_IRQ_ENABLE_OFS: rdata_next = h_irq_enable_reg;
			`H_EDGE_FLAGS_OFS: rdata_next = h_edge_flags_reg;
			`J_DATA_OFS: rdata_next = (j_data_reg & j_direction_reg)
				| (j_sync_reg & ~j_direction_reg);
			`J_PIN_INPUT_OFS: rdata_next = j_sync_reg;
			`J_DIRECTION_OFS: rdata_next = j_direction_reg;
			default: rdata_next = `REG_RESET;
		endcase
	end

	// Read data stands only in the cycle after the strobe and reads zero else.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `REG_RESET;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : `REG_RESET;
		end
	end

endmodule : gpio_ports_g_h_j

/* sim/gpio_ports_monitor.sv */
// Purpose: Concurrent checks on the port G/H/J block at its ports.
// Assumes: Takeover enables stay low while reset is asserted.
// Notes: Attached to every instance of the block by the bind below.
`timescale 1ns/1ps
module gpio_ports_monitor
	import gpio_ports_pkg::*;
(
	// Clock, reset and bus.
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_rd,
	input wire pin_vec_t reg_rdata,
	// Takeover inputs.
	input wire logic ext_mii_en,
	input wire logic two_wire_en,
	input wire pin_vec_t mii_h_out,
	input wire pin_vec_t mii_j_oe,
	input wire pin_vec_t twi_j_oe,
	// Pad controls and requests.
	input wire pin_vec_t h_pin_out,
	input wire pin_vec_t h_pin_oe,
	input wire pin_vec_t h_pin_weak,
	input wire pin_vec_t h_pull_on,
	input wire pin_vec_t h_pull_down,
	input wire pin_vec_t j_pin_oe,
	input wire logic g_irq,
	input wire logic h_irq,
	input wire logic irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// A cycle with no read strobe leaves the next read data at zero.
	sequence s_no_read;
		!reg_rd;
	endsequence
	property p_rd_idle;
		s_no_read |=> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data seen outside its cycle");
	property p_unimpl;
		h_pin_oe[7] == 1'b0 && j_pin_oe[5:4] == 2'b00;
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("unimplemented pin driven");
	property p_weak;
		(h_pin_weak & ~h_pin_oe) == 8'h00;
	endproperty
	a_weak: assert property (p_weak)
		else $error("reduced drive on an input pin");
	property p_pull;
		(h_pull_on & h_pin_oe) == 8'h00;
	endproperty
	a_pull: assert property (p_pull)
		else $error("pull active on a driven pin");
	property p_pdown;
		(h_pull_down & ~h_pull_on) == 8'h00;
	endproperty
	a_pdown: assert property (p_pdown)
		else $error("pull-down without pull enable");
	property p_irq;
		irq == (g_irq | h_irq);
	endproperty
	a_irq: assert property (p_irq)
		else $error("combined request differs from port requests");
	// The pads follow a takeover one edge later.
	property p_h_mii;
		$past(ext_mii_en) |-> h_pin_oe[6:0] == 7'h7f && h_pin_out[6:0] == $past(mii_h_out[6:0]);
	endproperty
	a_h_mii: assert property (p_h_mii)
		else $error("port H not carrying transmit lines");
	property p_j_mii;
		ext_mii_en |=> j_pin_oe[3:0] == $past(mii_j_oe[3:0]);
	endproperty
	a_j_mii: assert property (p_j_mii)
		else $error("port J low pins not steered by the MAC");
	property p_j_twi;
		two_wire_en |=> j_pin_oe[7:6] == $past(twi_j_oe[7:6]);
	endproperty
	a_j_twi: assert property (p_j_twi)
		else $error("port J high pins not steered by two-wire unit");
endmodule : gpio_ports_monitor

bind gpio_ports_g_h_j gpio_ports_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_mii_en(ext_mii_en),
	.two_wire_en(two_wire_en), .mii_h_out(mii_h_out), .mii_j_oe(mii_j_oe),
	.twi_j_oe(twi_j_oe), .h_pin_out(h_pin_out), .h_pin_oe(h_pin_oe),
	.h_pin_weak(h_pin_weak), .h_pull_on(h_pull_on), .h_pull_down(h_pull_down),
	.j_pin_oe(j_pin_oe), .g_irq(g_irq), .h_irq(h_irq), .irq(irq));

/* sim/pin_model.sv */
// Purpose: Pins and outside world of ports G, H and J.
// Assumes: A driven pin shows the driven level unless shorted.
// Notes: A short lets a bench scenario make a pin disagree with its latch.
`timescale 1ns/1ps
module pin_model
	import gpio_ports_pkg::*;
(
	// Outside levels and shorted H pins.
	input wire pin_vec_t ext_g,
	input wire pin_vec_t ext_h,
	input wire pin_vec_t ext_j,
	input wire pin_vec_t short_h,
	// Drive from the block.
	input wire pin_vec_t h_pin_out,
	input wire pin_vec_t h_pin_oe,
	input wire pin_vec_t j_pin_out,
	input wire pin_vec_t j_pin_oe,
	// Resolved levels.
	output pin_vec_t g_pin_in,
	output pin_vec_t h_pin_in,
	output pin_vec_t j_pin_in
);
	// Port G pins are inputs here, so the outside level always wins.
	assign g_pin_in = ext_g;
	assign h_pin_in = (h_pin_out & h_pin_oe & ~short_h) | (ext_h & ~(h_pin_oe & ~short_h));
	assign j_pin_in = (j_pin_out & j_pin_oe) | (ext_j & ~j_pin_oe);
endmodule : pin_model

/* sim/tb.sv */
// Purpose: Self-checking bench of the port G/H/J block.
// Assumes: 40 MHz clock, register strobes one cycle long.
// Notes: Pins come from pin_model, flags need several edges to settle.
`timescale 1ns/1ps
`include "gpio_ports_map.svh"
module tb
	import gpio_ports_pkg::*;
;
	logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic ext_mii_en = 1'b0, two_wire_en = 1'b0, g_irq, h_irq, irq;
	reg_addr_t reg_addr = 8'h00;
	pin_vec_t reg_wdata = 8'h00, g_direction = 8'h00, mii_h_out = 8'h00, mii_j_out = 8'h00;
	pin_vec_t mii_j_oe = 8'h00, twi_j_out = 8'h00, twi_j_oe = 8'h00, short_h = 8'h00;
	pin_vec_t ext_g = 8'h00, ext_h = 8'h00, ext_j = 8'h00, g_pin_in, h_pin_in, j_pin_in;
	pin_vec_t reg_rdata, g_pull_on, g_pull_down, h_pin_out, h_pin_oe, h_pin_weak;
	pin_vec_t h_pull_on, h_pull_down, j_pin_out, j_pin_oe, g_pin_sync, j_pin_sync;
	int num_checks = 0, n_mismatch = 0, cycles = 0;
	always #12.5 core_clk = ~core_clk;
	gpio_ports_g_h_j u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_mii_en(ext_mii_en), .two_wire_en(two_wire_en), .g_direction(g_direction),
		.mii_h_out(mii_h_out), .mii_j_out(mii_j_out), .mii_j_oe(mii_j_oe),
		.twi_j_out(twi_j_out), .twi_j_oe(twi_j_oe), .g_pin_in(g_pin_in),
		.g_pull_on(g_pull_on), .g_pull_down(g_pull_down), .g_pin_sync(g_pin_sync),
		.h_pin_in(h_pin_in), .h_pin_out(h_pin_out), .h_pin_oe(h_pin_oe),
		.h_pin_weak(h_pin_weak), .h_pull_on(h_pull_on), .h_pull_down(h_pull_down),
		.j_pin_in(j_pin_in), .j_pin_out(j_pin_out), .j_pin_oe(j_pin_oe),
		.j_pin_sync(j_pin_sync),
		.g_irq(g_irq), .h_irq(h_irq), .irq(irq));
	pin_model u_pins (.ext_g(ext_g), .ext_h(ext_h), .ext_j(ext_j), .short_h(short_h),
		.h_pin_out(h_pin_out), .h_pin_oe(h_pin_oe), .j_pin_out(j_pin_out),
		.j_pin_oe(j_pin_oe), .g_pin_in(g_pin_in), .h_pin_in(h_pin_in), .j_pin_in(j_pin_in));
	////////////////////////////////////////////////////////////////////////
	// Bus cycles, waits and comparisons.
	task automatic wr(input reg_addr_t a, input pin_vec_t d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic chk(input pin_vec_t got, input pin_vec_t exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rchk(input reg_addr_t a, input pin_vec_t exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rchk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset_values();
		for (int a = 8'h14; a <= 8'h22; a++) begin
			rchk(reg_addr_t'(a), 8'h00);
		end
		rchk(8'h30, 8'h00);
		chk(g_pull_on | h_pull_on, 8'h00);
	endtask : t_reset_values
	task automatic t_dir_data();
		@(posedge core_clk);
		ext_h <= 8'h33;
		short_h <= 8'h01;
		wr(`H_DIRECTION_OFS, 8'hff);
		rchk(`H_DIRECTION_OFS, 8'h7f);
		wr(`H_DIRECTION_OFS, 8'h00);
		cyc(2);
		rchk(`H_DATA_OFS, 8'h33);
		wr(`H_DIRECTION_OFS, 8'h0f);
		wr(`H_DATA_OFS, 8'ha4);
		wr(`H_PIN_INPUT_OFS, 8'hff);
		cyc(2);
		chk(h_pin_oe, 8'h0f);
		chk(h_pin_out & h_pin_oe, 8'h04);
		rchk(`H_DATA_OFS, 8'h34);
		rchk(`H_PIN_INPUT_OFS, 8'h35);
		@(posedge core_clk);
		short_h <= 8'h00;
	endtask : t_dir_data
	task automatic t_pads();
		wr(`H_PULL_ENABLE_OFS, 8'hff);
		wr(`H_POLARITY_SELECT_OFS, 8'h3c);
		wr(`H_REDUCED_DRIVE_OFS, 8'hff);
		cyc(2);
		chk(h_pull_on, 8'h70);
		chk(h_pull_down, 8'h30);
		chk(h_pin_weak, 8'h0f);
	endtask : t_pads
	task automatic t_g_edges();
		@(posedge core_clk);
		ext_g <= 8'h02;
		wr(`G_POLARITY_SELECT_OFS, 8'h01);
		cyc(6);
		wr(`G_EDGE_FLAGS_OFS, 8'hff);
		ext_g <= 8'h01;
		cyc(6);
		rchk(`G_EDGE_FLAGS_OFS, 8'h03);
		chk(pin_vec_t'({g_irq, irq}), 8'h00);
		wr(`G_IRQ_ENABLE_OFS, 8'h02);
		cyc(2);
		chk(pin_vec_t'({g_irq, irq}), 8'h03);
		wr(`G_EDGE_FLAGS_OFS, 8'h01);
		rchk(`G_EDGE_FLAGS_OFS, 8'h02);
		wr(`G_EDGE_FLAGS_OFS, 8'h02);
		ext_g <= 8'h02;
		cyc(6);
		rchk(`G_EDGE_FLAGS_OFS, 8'h00);
		chk(pin_vec_t'({g_irq, irq}), 8'h00);
	endtask : t_g_edges
	task automatic t_h_irq();
		wr(`H_POLARITY_SELECT_OFS, 8'h40);
		wr(`H_IRQ_ENABLE_OFS, 8'h40);
		wr(`H_EDGE_FLAGS_OFS, 8'hff);
		ext_h <= 8'h73;
		cyc(6);
		rchk(`H_EDGE_FLAGS_OFS, 8'h40);
		chk(pin_vec_t'({h_irq, irq}), 8'h03);
		wr(`H_EDGE_FLAGS_OFS, 8'h40);
		cyc(2);
		chk(pin_vec_t'({h_irq, irq}), 8'h00);
	endtask : t_h_irq
	task automatic t_takeover();
		wr(`J_DIRECTION_OFS, 8'hff);
		wr(`G_PULL_ENABLE_OFS, 8'hff);
		g_direction <= 8'hff;
		cyc(2);
		chk(g_pull_on, 8'h00);
		@(posedge core_clk);
		{ext_mii_en, two_wire_en, mii_h_out, mii_j_out} <= {2'b11, 8'h55, 8'h03};
		{mii_j_oe, twi_j_out, twi_j_oe} <= {8'h05, 8'h80, 8'h40};
		cyc(2);
		chk(g_pull_on, 8'h7f);
		chk(h_pin_oe, 8'h7f);
		chk(h_pin_out, 8'h55);
		chk(j_pin_oe, 8'h45);
		chk(j_pin_out & j_pin_oe, 8'h01);
		chk(g_pull_down, 8'h01);
		rchk(`J_DIRECTION_OFS, 8'hcf);
		chk(j_pin_sync, 8'h01);
		chk(g_pin_sync, 8'h02);
		rchk(`J_PIN_INPUT_OFS, 8'h01);
		@(posedge core_clk);
		{ext_mii_en, two_wire_en} <= 2'b00;
		cyc(2);
		chk(j_pin_oe, 8'hcf);
		chk(h_pin_oe, 8'h0f);
	endtask : t_takeover
	////////////////////////////////////////////////////////////////////////
	// Hang guard and main sequence.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset_values();
		t_dir_data();
		t_pads();
		t_g_edges();
		t_h_irq();
		t_takeover();
		close_out();
	end
endmodule : tb
